// file: verilog/pdc_regs.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] back-off level code 0 normal, 1..3 reduced drive, others reserved
// [R2] writing one to regulator power-down powers regulator off; self clearing
// [R3] regulator stays powered and drives feedback pin while bit is zero; here it stays off from a power-down until reset, though the bit reads zero
// [R4] software writes zeros to reserved regulator bits 14..4
// [R5] software ignores regulator control nibble on read; read then write
// [R6] length-estimate average factor, bits 2..0 read-write, reset 001
// [R7] cross disable one gives regular mode only; zero enables cross diagnosis
// [R8] cross mode looks for reflections on opposite pair to find shorts
// [R9] transmit bypass one skips transmit pair test
// [R10] transmit bypass places results in receive pair slots
// [R11] receive bypass one skips receive pair test
// [R12] software keeps main control bit 11 at one; resets to one
// [R13] averaging count runs 2^code cycles, default 110, 111 reserved
// [R14] pulse control nibble sets expected self reflection, reset 1100
// [R15] listen duration byte for long cables, reset all ones
// [R16] short cable threshold five bits, reset 11000
// [R17] software trusts peak results only after reading done bit one
// [R18] registers are 16 bits; read-only reserved bits return reset values
// [R19] writing start launches estimate; bit clears once engine accepts; here the read bit stays one until done
module pdc_regs (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // register port
    input  wire pdc_pkg::pdc_req_t req,
    output var  logic [15:0]       rdData,
    // length-estimate engine
    input  wire logic              lenAccept,
    input  wire logic              lenDone,
    input  wire logic [7:0]        lenResult,
    output var  logic              lenStart,
    output var  logic [2:0]        lenAvg,
    // power and diagnostic controls
    output var  logic [2:0]        backoffLevel,
    output var  logic              regulatorOn,
    output var  logic [3:0]        regulatorCtl,
    output var  pdc_pkg::pdc_diag_t diagCfg
);
    typedef enum logic [1:0] {PDC_IDLE = 2'b00, PDC_REQ = 2'b01, PDC_WAIT = 2'b11} pdc_est_t;

    // averaging code to cycle count; reserved code falls back to default
    function automatic logic [6:0] pdc_avg_count(input logic [2:0] code);
        logic [2:0] c;
        c = (code == pdc_pkg::AVG_RESERVED) ? pdc_pkg::AVG_RST : code;
        return 7'(7'h01 << c);
    endfunction

    logic [2:0]  backoff_q;
    logic        regPd_q;
    logic [10:0] regRsv_q;
    logic [3:0]  regCtl_q;
    logic [2:0]  lenAvg_q;
    logic        crossDis_q, txByp_q, rxByp_q, keepOne_q;
    logic [2:0]  avg_q;
    logic [11:0] pulseHi_q;
    logic [3:0]  pulse_q;
    logic [7:0]  listen_q, listenLo_q;
    logic [2:0]  threshHi_q;
    logic [4:0]  thresh_q;
    logic [7:0]  threshLo_q;
    logic        done_q;
    logic [7:0]  result_q;
    logic [15:0] rd_q;
    logic        pwrOn_q;
    pdc_est_t    est_q, est_d;
    pdc_pkg::pdc_diag_t diag_q;

    // address decode
    wire hitBackoff = req.addr == pdc_pkg::OFF_BACKOFF;
    wire hitRegCtl  = req.addr == pdc_pkg::OFF_REGCTL;
    wire hitLenEst  = req.addr == pdc_pkg::OFF_LENEST;
    wire hitMain    = req.addr == pdc_pkg::OFF_DIAGMAIN;
    wire hitPulse   = req.addr == pdc_pkg::OFF_PULSE;
    wire hitListen  = req.addr == pdc_pkg::OFF_LISTEN;
    wire hitThresh  = req.addr == pdc_pkg::OFF_THRESH;
    wire [15:0] wd  = req.wdata;

    // reserved back-off codes are refused so the drive never leaves a legal level
    wire [2:0] boNew = wd[pdc_pkg::BACKOFF_LSB +: 3];
    wire boLegal = boNew <= pdc_pkg::BACKOFF_MAX; // R1

    // a start write is only taken while the sequencer is idle
    wire startWr = req.wr && hitLenEst && wd[pdc_pkg::LEN_START_BIT];

    // read mux; the fixed pattern holds the back-off reserved bits
    wire [15:0] rdMux =
        hitBackoff ? (pdc_pkg::BACKOFF_FIXED | (16'(backoff_q) << pdc_pkg::BACKOFF_LSB)) : // R18
        hitRegCtl  ? {regPd_q, regRsv_q, regCtl_q} :
        hitLenEst  ? {(est_q != PDC_IDLE), 2'b00, done_q, result_q, 1'b0, lenAvg_q} : // R18
        hitMain    ? {1'b0, crossDis_q, txByp_q, rxByp_q, keepOne_q, avg_q, 8'h00} : // R18
        hitPulse   ? {pulseHi_q, pulse_q} :
        hitListen  ? {listen_q, listenLo_q} :
        hitThresh  ? {threshHi_q, thresh_q, threshLo_q} : 16'h0000;

    // derived configuration for the reflectometry engine
    pdc_pkg::pdc_diag_t diagNext;
    assign diagNext.crossEn      = ~crossDis_q;          // R7 R8
    assign diagNext.testTx       = ~txByp_q;             // R9
    assign diagNext.testRx       = ~rxByp_q;             // R11
    assign diagNext.rxSlotsForTx = txByp_q;              // R10
    assign diagNext.avgCycles    = pdc_avg_count(avg_q); // R13
    assign diagNext.pulseLevel   = pulse_q;              // R14
    assign diagNext.listenTime   = listen_q;             // R15
    assign diagNext.shortThresh  = thresh_q;             // R16

    // estimate start handshake: request held until the engine accepts
    always_comb begin
        est_d = est_q;
        case (est_q)
            PDC_IDLE: if (startWr) est_d = PDC_REQ;  // R19
            PDC_REQ:  if (lenAccept) est_d = PDC_WAIT; // R19
            PDC_WAIT: if (lenDone) est_d = PDC_IDLE;
            default:  est_d = PDC_IDLE;
        endcase
    end

    // power and regulator registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            backoff_q <= pdc_pkg::BACKOFF_RST;
            regPd_q   <= 1'b0;
            regRsv_q  <= 11'h000;
            regCtl_q  <= 4'h0;
        end else begin
            if (req.wr && hitBackoff && boLegal) backoff_q <= boNew; // R1
            // power-down pulses once, then the bit clears itself
            regPd_q <= req.wr && hitRegCtl && wd[pdc_pkg::REG_PD_BIT]; // R2
            if (req.wr && hitRegCtl) begin
                regRsv_q <= wd[14:4];
                regCtl_q <= wd[3:0];
            end
        end
    end

    // regulator enable: once powered down it stays down until reset
    always_ff @(posedge clk_sys) begin
        if (rst) pwrOn_q <= 1'b1;
        else if (regPd_q) pwrOn_q <= 1'b0; // R2 R3
    end

    // diagnostic control registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            crossDis_q <= 1'b0;
            txByp_q    <= 1'b0;
            rxByp_q    <= 1'b0;
            keepOne_q  <= 1'b1; // R12
            avg_q      <= pdc_pkg::AVG_RST; // R13
        end else if (req.wr && hitMain) begin
            crossDis_q <= wd[pdc_pkg::CROSS_DIS_BIT]; // R7
            txByp_q    <= wd[pdc_pkg::TX_BYP_BIT];    // R9
            rxByp_q    <= wd[pdc_pkg::RX_BYP_BIT];    // R11
            keepOne_q  <= wd[pdc_pkg::KEEP_ONE_BIT];
            avg_q      <= wd[pdc_pkg::AVG_LSB +: 3];  // R13
        end
    end

    // tuning registers; reserved read-write bits are plain storage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pulseHi_q  <= pdc_pkg::PULSE_HI_RST;
            pulse_q    <= pdc_pkg::PULSE_RST;     // R14
            listen_q   <= pdc_pkg::LISTEN_RST;    // R15
            listenLo_q <= pdc_pkg::LISTEN_LO_RST;
            threshHi_q <= pdc_pkg::THRESH_HI_RST;
            thresh_q   <= pdc_pkg::THRESH_RST;    // R16
            threshLo_q <= pdc_pkg::THRESH_LO_RST;
        end else begin
            if (req.wr && hitPulse) {pulseHi_q, pulse_q} <= wd; // R14
            if (req.wr && hitListen) {listen_q, listenLo_q} <= wd; // R15
            if (req.wr && hitThresh) {threshHi_q, thresh_q, threshLo_q} <= wd; // R16
        end
    end

    // length estimate control and status; a new start clears done
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lenAvg_q <= pdc_pkg::LEN_AVG_RST; // R6
            done_q   <= 1'b0;
            result_q <= 8'h00;
            est_q    <= PDC_IDLE;
        end else begin
            est_q <= est_d;
            if (req.wr && hitLenEst) lenAvg_q <= wd[2:0]; // R6
            // done from the engine wins over the clear by a new start
            if (est_q == PDC_WAIT && lenDone) begin
                done_q   <= 1'b1;
                result_q <= lenResult;
            end else if (startWr && est_q == PDC_IDLE) begin
                done_q <= 1'b0;
            end
        end
    end

    // registered outputs and read data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_q   <= 16'h0000;
            diag_q <= '0;
        end else begin
            rd_q   <= req.rd ? rdMux : 16'h0000;
            diag_q <= diagNext;
        end
    end

    assign rdData       = rd_q;
    assign lenStart     = (est_q == PDC_REQ); // R19
    assign lenAvg       = lenAvg_q;
    assign backoffLevel = backoff_q;
    assign regulatorOn  = pwrOn_q; // R3
    assign regulatorCtl = regCtl_q;
    assign diagCfg      = diag_q;
endmodule
`default_nettype wire

// file: include/pdc_pkg.sv
package pdc_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 9;

    // register offsets
    localparam logic [8:0] OFF_BACKOFF  = 9'h0ae;
    localparam logic [8:0] OFF_REGCTL   = 9'h0b0;
    localparam logic [8:0] OFF_LENEST   = 9'h155;
    localparam logic [8:0] OFF_DIAGMAIN = 9'h170;
    localparam logic [8:0] OFF_PULSE    = 9'h171;
    localparam logic [8:0] OFF_LISTEN   = 9'h173;
    localparam logic [8:0] OFF_THRESH   = 9'h177;

    // field positions
    localparam int unsigned BACKOFF_LSB   = 6;
    localparam int unsigned REG_PD_BIT    = 15;
    localparam int unsigned LEN_START_BIT = 15;
    localparam int unsigned LEN_DONE_BIT  = 12;
    localparam int unsigned LEN_OUT_LSB   = 4;
    localparam int unsigned CROSS_DIS_BIT = 14;
    localparam int unsigned TX_BYP_BIT    = 13;
    localparam int unsigned RX_BYP_BIT    = 12;
    localparam int unsigned KEEP_ONE_BIT  = 11;
    localparam int unsigned AVG_LSB       = 8;
    localparam int unsigned LISTEN_LSB    = 8;
    localparam int unsigned THRESH_LSB    = 8;

    // reset values, plus the back-off code limit and the reserved averaging code
    localparam logic [15:0] BACKOFF_FIXED  = 16'h8020;
    localparam logic [2:0]  BACKOFF_RST    = 3'h0;
    localparam logic [2:0]  LEN_AVG_RST    = 3'h1;
    localparam logic [2:0]  AVG_RST        = 3'h6;
    localparam logic [2:0]  AVG_RESERVED   = 3'h7;
    localparam logic [2:0]  BACKOFF_MAX    = 3'h3;
    localparam logic [11:0] PULSE_HI_RST   = 12'hc85;
    localparam logic [3:0]  PULSE_RST      = 4'hc;
    localparam logic [7:0]  LISTEN_RST     = 8'hff;
    localparam logic [7:0]  LISTEN_LO_RST  = 8'hff;
    localparam logic [2:0]  THRESH_HI_RST  = 3'h0;
    localparam logic [4:0]  THRESH_RST     = 5'h18;
    localparam logic [7:0]  THRESH_LO_RST  = 8'h96;

    // register port request
    typedef struct packed {
        logic [8:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pdc_req_t;

    // diagnostic configuration towards the analog engine
    typedef struct packed {
        logic       crossEn;
        logic       testTx;
        logic       testRx;
        logic       rxSlotsForTx;
        logic [6:0] avgCycles;
        logic [3:0] pulseLevel;
        logic [7:0] listenTime;
        logic [4:0] shortThresh;
    } pdc_diag_t;
endpackage

// file: testbench/pdc_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// watches the register port against the control outputs
module pdc_regs_properties (
    // clock and reset
    input wire logic               clk_sys,
    input wire logic               rst,
    // observed ports
    input wire pdc_pkg::pdc_req_t  req,
    input wire logic [15:0]        rdData,
    input wire logic               lenAccept,
    input wire logic               lenStart,
    input wire logic [2:0]         lenAvg,
    input wire logic [2:0]         backoffLevel,
    input wire logic               regulatorOn,
    input wire pdc_pkg::pdc_diag_t diagCfg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // a write strobe aimed at one offset
    sequence s_wr(a);
        req.wr && req.addr == a;
    endsequence
    a_read_idle_zero: assert property (!$past(req.rd) |-> rdData == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_backoff_write: assert property (s_wr(pdc_pkg::OFF_BACKOFF) |=> backoffLevel ==
        ($past(req.wdata[8:6]) <= 3'h3 ? $past(req.wdata[8:6]) : $past(backoffLevel)))
        else $error("back-off level wrong after write");
    a_backoff_legal: assert property (backoffLevel <= pdc_pkg::BACKOFF_MAX)
        else $error("back-off level reserved");
    // the power-down bit is stored one cycle, the enable drops the cycle after that
    a_reg_stays_on: assert property (regulatorOn &&
        !(req.wr && req.addr == pdc_pkg::OFF_REGCTL && req.wdata[15]) &&
        !$past(req.wr && req.addr == pdc_pkg::OFF_REGCTL && req.wdata[15]) |=> regulatorOn)
        else $error("regulator dropped");
    a_reg_power_down: assert property (s_wr(pdc_pkg::OFF_REGCTL) ##0 req.wdata[15]
        |-> ##2 !regulatorOn [*3]) else $error("regulator not powered down");
    a_start_launch: assert property ($rose(lenStart) |->
        $past(req.wr && req.addr == pdc_pkg::OFF_LENEST && req.wdata[15]))
        else $error("start without start write");
    a_start_hold: assert property (lenStart && !lenAccept |=> lenStart)
        else $error("start dropped before accept");
    a_start_clear: assert property (lenStart && lenAccept |=> !lenStart)
        else $error("start kept after accept");
    a_avg_factor: assert property (s_wr(pdc_pkg::OFF_LENEST) |=>
        lenAvg == $past(req.wdata[2:0])) else $error("average factor not written");
    a_cross_mode: assert property (s_wr(pdc_pkg::OFF_DIAGMAIN) |-> ##2
        diagCfg.crossEn == !$past(req.wdata[14], 2)) else $error("cross mode wrong");
    a_tx_bypass: assert property (s_wr(pdc_pkg::OFF_DIAGMAIN) |-> ##2
        diagCfg.testTx != $past(req.wdata[13], 2) &&
        diagCfg.rxSlotsForTx == $past(req.wdata[13], 2)) else $error("tx bypass wrong");
    a_rx_bypass: assert property (s_wr(pdc_pkg::OFF_DIAGMAIN) |-> ##2
        diagCfg.testRx != $past(req.wdata[12], 2)) else $error("rx bypass wrong");
    a_avg_cycles: assert property (s_wr(pdc_pkg::OFF_DIAGMAIN) |-> ##2
        diagCfg.avgCycles == ($past(req.wdata[10:8], 2) == 3'h7 ? 7'h40 :
        7'h01 << $past(req.wdata[10:8], 2))) else $error("average cycles wrong");
endmodule
`default_nettype wire

// file: testbench/pdc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_regs_tb;
    logic               clk_sys = 1'b0;
    logic               rst = 1'b1;
    pdc_pkg::pdc_req_t  req = '0;
    logic               lenAccept = 1'b0;
    logic               lenDone = 1'b0;
    logic [7:0]         lenResult = 8'h00;
    logic [15:0]        rdData;
    logic               lenStart;
    logic [2:0]         lenAvg;
    logic [2:0]         backoffLevel;
    logic               regulatorOn;
    logic [3:0]         regulatorCtl;
    pdc_pkg::pdc_diag_t diagCfg;
    int                 bad_count = 0;
    int                 check_count = 0;
    int                 cycles = 0;
    int                 seed = 88894;
    logic [15:0]        d;
    logic [2:0]         lvl;
    logic [15:0]        v [3];
    logic [8:0]         tuneAddr [3] = '{pdc_pkg::OFF_PULSE, pdc_pkg::OFF_LISTEN,
                                         pdc_pkg::OFF_THRESH};
    pdc_regs DUT (.clk_sys(clk_sys), .rst(rst), .req(req), .rdData(rdData),
        .lenAccept(lenAccept), .lenDone(lenDone), .lenResult(lenResult),
        .lenStart(lenStart), .lenAvg(lenAvg), .backoffLevel(backoffLevel),
        .regulatorOn(regulatorOn), .regulatorCtl(regulatorCtl), .diagCfg(diagCfg));
    always #2 clk_sys = ~clk_sys;
    // hang guard, the whole run needs about 130 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // one-cycle strobes, driven just after the edge
    task automatic wr(input logic [8:0] a, input logic [15:0] w);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [8:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1;
        chk(rdData & m, e & m);
    endtask
    // code 111 is reserved; the design runs 64 cycles for it
    function automatic logic [6:0] avgFor(input logic [2:0] c);
        return (c == 3'h7) ? 7'h40 : 7'h01 << c;
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        // reset image of every register except regulator control, plus an unmapped hole
        rd(pdc_pkg::OFF_BACKOFF, 16'h8020, 16'hffff);
        rd(pdc_pkg::OFF_LENEST, 16'h0001, 16'hffff);
        rd(pdc_pkg::OFF_DIAGMAIN, 16'h0e00, 16'hffff);
        rd(pdc_pkg::OFF_PULSE, 16'hc85c, 16'hffff);
        rd(pdc_pkg::OFF_LISTEN, 16'hffff, 16'hffff);
        rd(pdc_pkg::OFF_THRESH, 16'h1896, 16'hffff);
        rd(9'h100, 16'h0000, 16'hffff);
        chk({diagCfg.crossEn, diagCfg.testTx, diagCfg.testRx, 2'h0, diagCfg.avgCycles,
            diagCfg.pulseLevel}, 16'he40c);
        chk({diagCfg.listenTime, 3'h0, diagCfg.shortThresh}, 16'hff18);
        chk({12'h000, lenAvg, regulatorOn}, 16'h0003);
        // every back-off code, reserved ones must leave the level alone
        lvl = 3'h0;
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            d[8:6] = i[2:0];
            if (i < 4) lvl = i[2:0];
            wr(pdc_pkg::OFF_BACKOFF, d);
            rd(pdc_pkg::OFF_BACKOFF, 16'h8020 | {7'h00, lvl, 6'h00}, 16'hffff);
        end
        // every averaging code with random bypass and cross bits
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            d[10:8] = i[2:0];
            d[11] = 1'b1;
            wr(pdc_pkg::OFF_DIAGMAIN, d);
            @(posedge clk_sys);
            #1;
            chk({diagCfg.crossEn, diagCfg.testTx, diagCfg.testRx, diagCfg.rxSlotsForTx,
                5'h00, diagCfg.avgCycles}, {~d[14:12], d[13], 5'h00, avgFor(i[2:0])});
            rd(pdc_pkg::OFF_DIAGMAIN, d & 16'h7f00, 16'hffff);
        end
        for (int i = 0; i < 3; i++) begin
            v[i] = $random(seed);
            wr(tuneAddr[i], v[i]);
            rd(tuneAddr[i], v[i], 16'hffff);
        end
        chk({3'h0, diagCfg.shortThresh, diagCfg.listenTime}, {3'h0, v[2][12:8], v[1][15:8]});
        chk({12'h000, diagCfg.pulseLevel}, {12'h000, v[0][3:0]});
        // estimate start held three cycles before the engine accepts
        wr(pdc_pkg::OFF_LENEST, 16'h8005);
        chk({15'h0000, lenStart}, 16'h0001);
        rd(pdc_pkg::OFF_LENEST, 16'h8005, 16'hffff);
        @(posedge clk_sys);
        lenAccept <= 1'b1;
        d = $random(seed);
        @(posedge clk_sys);
        lenAccept <= 1'b0;
        lenDone <= 1'b1;
        lenResult <= d[7:0];
        @(posedge clk_sys);
        lenDone <= 1'b0;
        #1;
        chk({15'h0000, lenStart}, 16'h0000);
        rd(pdc_pkg::OFF_LENEST, {4'h1, d[7:0], 4'h5}, 16'hffff);
        // regulator: read first, then write, nibble alone keeps power
        rd(pdc_pkg::OFF_REGCTL, 16'h0000, 16'hfff0);
        wr(pdc_pkg::OFF_REGCTL, 16'h0005);
        chk({11'h000, regulatorOn, regulatorCtl}, 16'h0015);
        wr(pdc_pkg::OFF_REGCTL, 16'h8005);
        repeat (3) @(posedge clk_sys);
        chk({15'h0000, regulatorOn}, 16'h0000);
        rd(pdc_pkg::OFF_REGCTL, 16'h0000, 16'hfff0);
        // second reset in mid-run restores power and back-off
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(pdc_pkg::OFF_BACKOFF, 16'h8020, 16'hffff);
        chk({15'h0000, regulatorOn}, 16'h0001);
        final_report();
    end
endmodule
bind pdc_regs pdc_regs_properties u_props (.clk_sys(clk_sys), .rst(rst), .req(req),
    .rdData(rdData), .lenAccept(lenAccept), .lenStart(lenStart), .lenAvg(lenAvg),
    .backoffLevel(backoffLevel), .regulatorOn(regulatorOn), .diagCfg(diagCfg));
`default_nettype wire
